// *** hw/asr_regs.svh ***
/*
 Timing constants for the asynchronous static memory controller.
 Assumes a 250 MHz system clock; included by the controller files.
*/
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

// Clock period in picoseconds
`define ASR_CLK_PS 4000
// Slowest grade figures, in ns
`define ASR_ADDR_ACCESS_NS 20
`define ASR_GATE_VALID_NS 9
`define ASR_WRITE_GATED_NS 20
`define ASR_WRITE_END_DRIVE_NS 3
`define ASR_FLOAT_NS 9
// Derived cycle counts, least times rounded up
`define ASR_CYC(ns) (((ns) * 1000 + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_READ_CYC `ASR_CYC(`ASR_ADDR_ACCESS_NS)
`define ASR_WRITE_CYC `ASR_CYC(`ASR_WRITE_GATED_NS)
`define ASR_FLOAT_CYC `ASR_CYC(`ASR_FLOAT_NS)
// Read window beyond access: two synchroniser flops and one settling cycle
`define ASR_SYNC_MARGIN_CYC 3
// Word geometry
`define ASR_ADDR_W 20
`define ASR_DATA_W 4

`endif

// *** hw/asr_pkg.sv ***
/*
 Types for the asynchronous static memory controller.
 Assumes asr_regs.svh for the widths.
*/
`include "asr_regs.svh"
package asr_pkg;
	typedef enum logic [4:0] {
		ASR_IDLE = 5'h01,
		ASR_RD = 5'h02,
		ASR_WR_SET = 5'h04,
		ASR_WR = 5'h08,
		ASR_TURN = 5'h10
	} asr_state_t;
	typedef logic [`ASR_ADDR_W-1:0] asr_addr_t;
	typedef logic [`ASR_DATA_W-1:0] asr_data_t;
endpackage

// *** hw/asr_sync.sv ***
/*
 Two flip-flop synchroniser for the data lines read back from memory.
 Assumes the memory drives asynchronously to sys_clk.
*/
`timescale 1ns/1ps
module asr_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // asr_sync

// *** hw/asr_ctrl.sv ***
/*
 Controller for a 1M x 4 asynchronous static memory: takes single-word
 read and write requests and sequences address, strobes and data lines.
 Assumes the memory sits on the pins directly and the requester uses
 sys_clk. Timing is set by the slowest speed grade, so any grade works.
 Writes keep the output gate high throughout, so the memory never drives
 while the controller does; single words only, no bursts.
*/
// Contract
// - Controller never drives data lines while memory reads out.
// - Read holds write strobe high, select and gate low.
// - Write interval at least 12 ns, 15 ns with gate low.
// - Select held low at least 12 ns to end of write.
// - Address valid no later than select falling for reads.
// - Strobes sequenced to avoid contention on the data lines.
`timescale 1ns/1ps
`include "asr_regs.svh"
module asr_ctrl #(
	parameter int READ_CYC = `ASR_READ_CYC,
	parameter int WRITE_CYC = `ASR_WRITE_CYC,
	parameter int TURN_CYC = `ASR_FLOAT_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Request
	input wire logic req_valid,
	input wire logic req_write,
	input wire asr_pkg::asr_addr_t req_addr,
	input wire asr_pkg::asr_data_t req_wdata,
	output logic req_ready,
	// Answer
	output logic rsp_valid,
	output asr_pkg::asr_data_t rsp_rdata,
	// Memory pins
	output asr_pkg::asr_addr_t word_address,
	output logic chip_select_n,
	output logic write_strobe_n,
	output logic output_gate_n,
	input wire asr_pkg::asr_data_t shared_data_lines_i,
	output asr_pkg::asr_data_t shared_data_lines_o,
	output logic shared_data_lines_oe
);
	import asr_pkg::*;

	// Read window: access time, two synchroniser flops, one cycle of
	// margin because the data may settle right on a clock edge
	localparam int READ_WIN = READ_CYC + `ASR_SYNC_MARGIN_CYC;

	// ****************************************************
	// Parameter checks
	// ****************************************************
	// All counts load an 8-bit down counter
	initial begin
		if (READ_CYC < 1 || READ_WIN > 256) begin
			$error("asr_ctrl: READ_CYC out of range");
		end
		if (WRITE_CYC < 1 || WRITE_CYC > 256) begin
			$error("asr_ctrl: WRITE_CYC out of range");
		end
		if (TURN_CYC < 1 || TURN_CYC > 256) begin
			$error("asr_ctrl: TURN_CYC out of range");
		end
	end

	// ****************************************************
	// State
	// ****************************************************
	typedef struct packed {
		asr_state_t st;
		logic [7:0] cnt;
		asr_addr_t addr;
		asr_data_t wdata;
		logic cs_n;
		logic we_n;
		logic oe_n;
		logic drv;
		logic ready;
		logic rvalid;
		asr_data_t rdata;
	} asr_ctrl_t;

	asr_ctrl_t s_r, s_nxt;
	asr_data_t din_sync;

	// ****************************************************
	// Read-back synchroniser
	// ****************************************************
	// Memory output is unclocked; only the second flop feeds logic
	asr_sync #(.WIDTH(`ASR_DATA_W)) u_sync (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in(shared_data_lines_i),
		.sync_out(din_sync)
	);

	// ****************************************************
	// Counter helpers
	// ****************************************************
	function automatic logic [7:0] cnt_of(input int n);
		cnt_of = 8'(n - 1);
	endfunction

	function automatic logic cnt_done(input logic [7:0] c);
		cnt_done = (c == 8'h00);
	endfunction

	// ****************************************************
	// Sequencer
	// ****************************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.rvalid = 1'b0;
		case (s_r.st)
			ASR_IDLE: begin
				// Idle deselected: memory floats, draws standby current
				s_nxt.cs_n = 1'b1;
				s_nxt.we_n = 1'b1;
				s_nxt.oe_n = 1'b1;
				s_nxt.drv = 1'b0;
				// Ready rises on the first edge after reset and after TURN
				s_nxt.ready = 1'b1;
				if (req_valid && s_r.ready) begin
					s_nxt.ready = 1'b0;
					s_nxt.addr = req_addr;
					s_nxt.wdata = req_wdata;
					if (req_write) begin
						// Select with gate high first: memory floats
						s_nxt.cs_n = 1'b0;
						s_nxt.st = ASR_WR_SET;
					end else begin
						// Address and select/gate leave together
						s_nxt.cs_n = 1'b0;
						s_nxt.oe_n = 1'b0;
						// Synchroniser and margin stretch the window
						s_nxt.cnt = cnt_of(READ_WIN);
						s_nxt.st = ASR_RD;
					end
				end
			end
			ASR_RD: begin
				if (cnt_done(s_r.cnt)) begin
					s_nxt.rdata = din_sync;
					// Deselect: memory floats within its release time
					s_nxt.rvalid = 1'b1;
					s_nxt.cs_n = 1'b1;
					s_nxt.oe_n = 1'b1;
					s_nxt.cnt = cnt_of(TURN_CYC);
					s_nxt.st = ASR_TURN;
				end else begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end
			end
			ASR_WR_SET: begin
				// Strobe falls after select, gate kept high, so the
				// memory never drives during the write
				s_nxt.we_n = 1'b0;
				s_nxt.drv = 1'b1;
				s_nxt.cnt = cnt_of(WRITE_CYC);
				s_nxt.st = ASR_WR;
			end
			ASR_WR: begin
				if (cnt_done(s_r.cnt)) begin
					// Strobe rises first; data and address held a cycle
					s_nxt.we_n = 1'b1;
					s_nxt.cnt = cnt_of(TURN_CYC);
					s_nxt.st = ASR_TURN;
				end else begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end
			end
			ASR_TURN: begin
				s_nxt.cs_n = 1'b1;
				s_nxt.drv = 1'b0;
				// Turnaround: lines float before anyone drives again
				if (cnt_done(s_r.cnt)) begin
					s_nxt.ready = 1'b1;
					s_nxt.st = ASR_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end
			end
			default: begin
				s_nxt.st = ASR_IDLE;
				s_nxt.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '{st: ASR_IDLE, cnt: 8'h00, addr: '0, wdata: '0,
				cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, drv: 1'b0,
				ready: 1'b0, rvalid: 1'b0, rdata: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************
	// Outputs
	// ****************************************************
	assign req_ready = s_r.ready;
	assign rsp_valid = s_r.rvalid;
	assign rsp_rdata = s_r.rdata;
	assign word_address = s_r.addr;
	assign chip_select_n = s_r.cs_n;
	assign write_strobe_n = s_r.we_n;
	assign output_gate_n = s_r.oe_n;
	assign shared_data_lines_o = s_r.wdata;
	assign shared_data_lines_oe = s_r.drv;
endmodule // asr_ctrl

// *** verification/asr_ctrl_asserts.sv ***
/* Pin sequencing checks for the memory controller.
 Assumes it is bound into asr_ctrl and sees its ports only. */
`timescale 1ns/1ps
module asr_ctrl_asserts #(
	parameter int READ_CYC = 5,
	parameter int WRITE_CYC = 5,
	parameter int TURN_CYC = 3
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Watched outputs
	input wire logic rsp_valid,
	input wire asr_pkg::asr_addr_t word_address,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	input wire logic shared_data_lines_oe
);
	import asr_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// ********
	// Strobes
	// ********
	property p_clash; shared_data_lines_oe |-> output_gate_n; endproperty
	a_clash: assert property (p_clash) else $error("drive with gate low");
	property p_rd; !output_gate_n |-> write_strobe_n && !chip_select_n;
	endproperty
	a_rd: assert property (p_rd) else $error("bad read strobes");
	property p_wr_start;
		$fell(write_strobe_n) |-> !$past(chip_select_n) && output_gate_n;
	endproperty
	a_wr_start: assert property (p_wr_start) else $error("bad write start");
	property p_wp;
		$fell(write_strobe_n) |-> !write_strobe_n[*5] ##1 write_strobe_n;
	endproperty
	a_wp: assert property (p_wp) else $error("bad write width");
	property p_cw;
		$rose(write_strobe_n) |-> !chip_select_n && !$past(chip_select_n, 6);
	endproperty
	a_cw: assert property (p_cw) else $error("select too short");
	property p_addr;
		!chip_select_n && !$fell(chip_select_n) |-> $stable(word_address);
	endproperty
	a_addr: assert property (p_addr) else $error("address moved");
	property p_rc;
		$fell(output_gate_n) |-> !output_gate_n[*8] ##1 rsp_valid;
	endproperty
	a_rc: assert property (p_rc) else $error("bad read length");
	property p_turn;
		$rose(chip_select_n) |-> !shared_data_lines_oe[*3];
	endproperty
	a_turn: assert property (p_turn) else $error("no turnaround");
	c_rd: cover property ($rose(rsp_valid));
	c_wr: cover property ($fell(write_strobe_n));
	c_sel: cover property ($fell(chip_select_n));
endmodule // asr_ctrl_asserts
bind asr_ctrl asr_ctrl_asserts #(.READ_CYC(READ_CYC), .WRITE_CYC(WRITE_CYC),
	.TURN_CYC(TURN_CYC)) i_chk (
	.sys_clk(sys_clk),
	.arst_n(arst_n),
	.rsp_valid(rsp_valid),
	.word_address(word_address),
	.chip_select_n(chip_select_n),
	.write_strobe_n(write_strobe_n),
	.output_gate_n(output_gate_n),
	.shared_data_lines_oe(shared_data_lines_oe)
);

// *** verification/asr_sram_model.sv ***
/* Behavioural 1M x 4 static memory on the controller pins.
 Assumes the bench resolves the shared lines into shared_data_lines_i. */
`timescale 1ns/1ps
module asr_sram_model #(
	parameter int ACCESS_NS = 20
) (
	// Pins
	input wire asr_pkg::asr_addr_t word_address,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	input wire asr_pkg::asr_data_t shared_data_lines_i,
	output asr_pkg::asr_data_t mem_q
);
	import asr_pkg::*;
	asr_data_t store [asr_addr_t];
	asr_data_t last = 4'h0;
	logic drive;
	logic writing;
	assign drive = !chip_select_n && write_strobe_n && !output_gate_n;
	assign writing = !chip_select_n && !write_strobe_n;
	logic wr_seen = 1'b0;
	// Captured at the end of the overlap; unknown start-up levels skipped
	always @(writing) begin
		if (wr_seen && writing !== 1'b1) begin
			store[word_address] = shared_data_lines_i;
		end
		wr_seen = (writing === 1'b1);
	end
	// Floating lines show garbage, so stale data never passes
	always @(word_address, drive) begin
		mem_q = ~last;
		if (drive) begin
			last = store.exists(word_address) ? store[word_address] : 4'h0;
			// Gate path is faster; address and gate move together here
			mem_q <= #ACCESS_NS last;
		end
	end
endmodule // asr_sram_model

// *** verification/tb_async_sram_1m_by_4_port.sv ***
/* Bench for asr_ctrl with a static memory model on its pins.
 Assumes asr_pkg, asr_ctrl and the checker are compiled first. */
`timescale 1ns/1ps
module tb_async_sram_1m_by_4_port;
	import asr_pkg::*;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic req_ready, rsp_valid, chip_select_n, write_strobe_n, output_gate_n;
	logic shared_data_lines_oe;
	asr_addr_t req_addr = 20'h0;
	asr_addr_t word_address;
	asr_data_t req_wdata = 4'h0;
	asr_data_t rsp_rdata, shared_data_lines_i, shared_data_lines_o, mem_q, q;
	int n_mismatch = 0;
	int tests_run = 0;
	assign shared_data_lines_i = shared_data_lines_oe ? shared_data_lines_o : mem_q;
	asr_ctrl i_dut (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.req_valid(req_valid),
		.req_write(req_write),
		.req_addr(req_addr),
		.req_wdata(req_wdata),
		.req_ready(req_ready),
		.rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata),
		.word_address(word_address),
		.chip_select_n(chip_select_n),
		.write_strobe_n(write_strobe_n),
		.output_gate_n(output_gate_n),
		.shared_data_lines_i(shared_data_lines_i),
		.shared_data_lines_o(shared_data_lines_o),
		.shared_data_lines_oe(shared_data_lines_oe)
	);
	asr_sram_model i_mem (
		.word_address(word_address),
		.chip_select_n(chip_select_n),
		.write_strobe_n(write_strobe_n),
		.output_gate_n(output_gate_n),
		.shared_data_lines_i(shared_data_lines_i),
		.mem_q(mem_q)
	);
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Held until taken; a stuck ready falls to the watchdog
	task automatic req(input logic w, input asr_addr_t a, input asr_data_t d);
		int i;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		// Ready is a flop: seen high now, it still stands at the next edge
		while (req_ready !== 1'b1) begin
			@(posedge sys_clk);
			#1;
		end
		@(posedge sys_clk);
		#1 req_valid = 1'b0;
		i = 0;
		while (!w && rsp_valid !== 1'b1 && i < 40) begin
			@(posedge sys_clk);
			#1;
			i++;
		end
		if (!w && rsp_valid !== 1'b1) begin
			n_mismatch++;
			$display("wrong value at %0t: no read answer", $time);
		end
		// Let an edge pass so valid never falls and rises in one step
		if (w) begin
			@(posedge sys_clk);
			#1;
		end
		q = rsp_rdata;
	endtask
	task automatic t_boundary;
		for (int k = 0; k < 2; k++) begin
			req(1'b1, k ? 20'hfffff : 20'h0, k ? 4'h9 : 4'h6);
		end
		req(1'b0, 20'h0, 4'h0);
		chk(q, 4'h6);
		req(1'b0, 20'hfffff, 4'h0);
		chk(q, 4'h9);
	endtask
	task automatic t_overwrite;
		req(1'b1, 20'h0a5a5, 4'h3);
		req(1'b1, 20'h05a5a, 4'hc);
		req(1'b1, 20'h0a5a5, 4'hf);
		req(1'b0, 20'h0a5a5, 4'h0);
		chk(q, 4'hf);
		req(1'b0, 20'h05a5a, 4'h0);
		chk(q, 4'hc);
	endtask
	task automatic t_refused;
		req(1'b1, 20'h12345, 4'ha);
		// Write still running: this one must be dropped
		chk(req_ready, 1'b0);
		req_wdata = 4'h5;
		req_valid = 1'b1;
		@(posedge sys_clk);
		#1 req_valid = 1'b0;
		@(posedge sys_clk);
		#1;
		req(1'b0, 20'h12345, 4'h0);
		chk(q, 4'ha);
	endtask
	task automatic t_reset;
		req(1'b1, 20'h00777, 4'h5);
		repeat (10) @(posedge sys_clk);
		#1 arst_n = 1'b0;
		@(posedge sys_clk);
		#1;
		chk({chip_select_n, write_strobe_n, output_gate_n}, 3'h7);
		arst_n = 1'b1;
		// Contents survive a controller reset with no refresh
		req(1'b0, 20'h00777, 4'h0);
		chk(q, 4'h5);
	endtask
	task automatic wrap_up;
		$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#20000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		chk({chip_select_n, write_strobe_n, output_gate_n}, 3'h7);
		#1 arst_n = 1'b1;
		t_boundary();
		t_overwrite();
		t_refused();
		t_reset();
		wrap_up();
	end
endmodule // tb_async_sram_1m_by_4_port
